/* common/isx_pkg.sv */
// Constants for the increment-skip and inclusive-OR execution block
// =====================================================================
package isx_pkg;
  // =====================================================================
  // Instruction word layout
  localparam int INSTR_W = 14;          // Instruction word width
  localparam int DATA_W = 8;            // Register data width
  localparam int ADDR_W = 7;            // File address width
  localparam int FILE_DEPTH = 128;      // Addresses 0 to 127
  localparam int OPC_MSB = 13;          // Opcode field top bit
  localparam int OPC_LSB = 8;           // Opcode field bottom bit
  localparam int DEST_BIT = 7;          // Destination select bit
  localparam int ADDR_MSB = 6;          // File address top bit
  localparam int LIT_MSB = 7;           // Immediate top bit
  // =====================================================================
  // Opcode encodings
  typedef enum logic [5:0] {
    OPC_NOP = 6'h00,                    // Nothing happens
    OPC_INC_SKIP_IF_ZERO = 6'h01,       // increment_skip_if_zero
    OPC_OR_IMMEDIATE_INTO_ACC = 6'h02,  // or_immediate_into_acc
    OPC_OR_ACC_WITH_FILE_REG = 6'h03    // or_acc_with_file_reg
  } isx_opc_e;
  // =====================================================================
  // Reset values and increment step
  localparam logic [7:0] ACC_RST = 8'h00;   // Accumulator after reset
  localparam logic [7:0] FILE_RST = 8'h00;  // File registers after reset
  localparam logic ZERO_RST = 1'b0;         // Zero flag after reset
  localparam logic [7:0] ONE = 8'h01;       // Increment step
endpackage

/* hdl/isx_core.sv */
// Execution unit for increment-skip and inclusive-OR instructions
`timescale 1ns/1ps
`default_nettype none
module isx_core (
  input wire logic SYS_CLK_I,                          // 10 MHz instruction clock
  input wire logic RST_B_I,                            // Synchronous reset, active low
  input wire logic INSTR_VALID_I,                      // One instruction offered this cycle
  input wire logic [isx_pkg::INSTR_W-1:0] INSTR_I,     // Instruction word
  input wire logic [isx_pkg::ADDR_W-1:0] PEEK_ADDR_I,  // File register to observe
  output logic [isx_pkg::DATA_W-1:0] PEEK_DATA_O,      // Observed file value, one cycle late
  output logic [isx_pkg::DATA_W-1:0] ACC_O,            // Working register
  output logic ZERO_O,                                 // Zero flag
  output logic SKIP_PENDING_O,                         // Next instruction will be squashed
  output logic EXEC_O,                                 // Pulse: instruction executed
  output logic SQUASH_O                                // Pulse: instruction replaced by no-op
);
  import isx_pkg::*;

  // =====================================================================
  // Storage
  logic [DATA_W-1:0] file_mem [FILE_DEPTH];  // File registers
  logic [DATA_W-1:0] acc;                    // Working register
  logic zero;                                // Zero flag
  logic skip_pend;                           // Skip armed by increment
  logic exec_pulse;                          // Executed marker
  logic squash_pulse;                        // Squashed marker
  logic [DATA_W-1:0] peek;                   // Registered peek data

  // Next values
  logic [DATA_W-1:0] next_acc;
  logic next_zero;
  logic next_skip_pend;
  logic next_exec_pulse;
  logic next_squash_pulse;
  logic [DATA_W-1:0] next_peek;
  logic file_we;                             // File write strobe
  logic [DATA_W-1:0] file_wdata;             // File write data

  // Decoded fields
  isx_opc_e opc;
  logic dest_file;                           // 1 selects file register
  logic [ADDR_W-1:0] faddr;
  logic [DATA_W-1:0] lit;
  logic [DATA_W-1:0] fval;                   // Addressed file contents
  logic [DATA_W-1:0] inc_res;
  logic [DATA_W-1:0] orf_res;
  logic [DATA_W-1:0] ori_res;
  logic exec;                                // Offered and not squashed

  // Zero test, shared by both OR paths
  function automatic logic is_zero(input logic [DATA_W-1:0] v);
    return v == '0;
  endfunction

  // =====================================================================
  // Decode
  assign opc = isx_opc_e'(INSTR_I[OPC_MSB:OPC_LSB]);
  assign dest_file = INSTR_I[DEST_BIT];
  assign faddr = INSTR_I[ADDR_MSB:0];
  assign lit = INSTR_I[LIT_MSB:0];
  assign fval = file_mem[faddr];
  assign inc_res = fval + ONE;
  assign orf_res = acc | fval;
  assign ori_res = acc | lit;
  assign exec = INSTR_VALID_I && !skip_pend;

  // =====================================================================
  // Next-state computation
  always_comb begin
    next_acc = acc;
    next_zero = zero;
    next_skip_pend = skip_pend;
    next_exec_pulse = 1'b0;
    next_squash_pulse = 1'b0;
    next_peek = file_mem[PEEK_ADDR_I];
    file_we = 1'b0;
    file_wdata = fval;
    if (INSTR_VALID_I && skip_pend) begin
      // Slot consumed as a no-op; skip is spent
      next_skip_pend = 1'b0;
      next_squash_pulse = 1'b1;
    end else if (exec) begin
      next_exec_pulse = 1'b1;
      unique case (opc)
        OPC_INC_SKIP_IF_ZERO: begin
          // Zero flag deliberately left alone
          if (dest_file) begin
            file_we = 1'b1;
            file_wdata = inc_res;
          end else begin
            next_acc = inc_res;
          end
          next_skip_pend = (inc_res == '0);
        end
        OPC_OR_IMMEDIATE_INTO_ACC: begin
          next_acc = ori_res;
          next_zero = is_zero(ori_res);
        end
        OPC_OR_ACC_WITH_FILE_REG: begin
          if (dest_file) begin
            file_we = 1'b1;
            file_wdata = orf_res;
          end else begin
            next_acc = orf_res;
          end
          next_zero = is_zero(orf_res);
        end
        default: begin
          // Other opcodes belong elsewhere in the core
        end
      endcase
    end
  end

  // =====================================================================
  // Control registers
  always_ff @(posedge SYS_CLK_I) begin
    if (!RST_B_I) begin
      acc <= ACC_RST;
      zero <= ZERO_RST;
      skip_pend <= 1'b0;
      exec_pulse <= 1'b0;
      squash_pulse <= 1'b0;
      peek <= FILE_RST;
    end else begin
      acc <= next_acc;
      zero <= next_zero;
      skip_pend <= next_skip_pend;
      exec_pulse <= next_exec_pulse;
      squash_pulse <= next_squash_pulse;
      peek <= next_peek;
    end
  end

  // =====================================================================
  // File register array; cleared on reset so results are never unknown
  always_ff @(posedge SYS_CLK_I) begin
    if (!RST_B_I) begin
      for (int i = 0; i < FILE_DEPTH; i++) begin
        file_mem[i] <= FILE_RST;
      end
    end else if (file_we) begin
      file_mem[faddr] <= file_wdata;
    end
  end

  assign ACC_O = acc;
  assign ZERO_O = zero;
  assign SKIP_PENDING_O = skip_pend;
  assign EXEC_O = exec_pulse;
  assign SQUASH_O = squash_pulse;
  assign PEEK_DATA_O = peek;

  // =====================================================================
  // Checks
  logic is_inc;
  logic is_ori;
  logic is_orf;
  assign is_inc = exec && opc == OPC_INC_SKIP_IF_ZERO;
  assign is_ori = exec && opc == OPC_OR_IMMEDIATE_INTO_ACC;
  assign is_orf = exec && opc == OPC_OR_ACC_WITH_FILE_REG;

  // Zero-result increment arms the skip; an offered slot under it is squashed.
  // Idle gaps may be any length, so the skip is checked one edge at a time
  // rather than with an open-ended wait for the next offered slot.
  sequence s_inc_wraps;
    is_inc && inc_res == '0;
  endsequence
  sequence s_squash_slot;
    INSTR_VALID_I && skip_pend;
  endsequence

  property p_inc_keeps_zero;
    @(posedge SYS_CLK_I) disable iff (!RST_B_I)
      is_inc |=> zero == $past(zero);
  endproperty
  a_inc_keeps_zero: assert property (p_inc_keeps_zero)
    else $error("increment changed zero flag");

  property p_inc_to_acc;
    @(posedge SYS_CLK_I) disable iff (!RST_B_I)
      is_inc && !dest_file |=> acc == $past(fval) + ONE;
  endproperty
  a_inc_to_acc: assert property (p_inc_to_acc)
    else $error("increment result missing from accumulator");

  property p_inc_to_file;
    @(posedge SYS_CLK_I) disable iff (!RST_B_I)
      is_inc && dest_file |=> file_mem[$past(faddr)] == $past(inc_res) && $stable(acc);
  endproperty
  a_inc_to_file: assert property (p_inc_to_file)
    else $error("increment result missing from file register");

  property p_inc_no_skip;
    @(posedge SYS_CLK_I) disable iff (!RST_B_I)
      is_inc && inc_res != '0 |=> !skip_pend;
  endproperty
  a_inc_no_skip: assert property (p_inc_no_skip)
    else $error("skip armed on nonzero result");

  property p_inc_skip;
    @(posedge SYS_CLK_I) disable iff (!RST_B_I)
      s_inc_wraps |=> skip_pend;
  endproperty
  a_inc_skip: assert property (p_inc_skip)
    else $error("wrapped increment did not arm the skip");

  // Offered slot under a pending skip becomes a no-op and spends the skip
  property p_skip_squashes;
    @(posedge SYS_CLK_I) disable iff (!RST_B_I)
      s_squash_slot |=> squash_pulse && !exec_pulse && !skip_pend
        && $stable(acc) && $stable(zero);
  endproperty
  a_skip_squashes: assert property (p_skip_squashes)
    else $error("instruction after wrapped increment not squashed");

  // Idle cycles leave a pending skip armed and squash nothing
  property p_skip_waits;
    @(posedge SYS_CLK_I) disable iff (!RST_B_I)
      skip_pend && !INSTR_VALID_I |=> skip_pend && !squash_pulse && !exec_pulse;
  endproperty
  a_skip_waits: assert property (p_skip_waits)
    else $error("pending skip lost on an idle cycle");

  property p_or_imm;
    @(posedge SYS_CLK_I) disable iff (!RST_B_I)
      is_ori |=> acc == ($past(acc) | $past(lit)) ##0 zero == (acc == '0);
  endproperty
  a_or_imm: assert property (p_or_imm)
    else $error("immediate OR result wrong");

  property p_or_file;
    @(posedge SYS_CLK_I) disable iff (!RST_B_I)
      is_orf |=> (($past(dest_file) ? file_mem[$past(faddr)] : acc) == $past(orf_res))
        && zero == ($past(orf_res) == '0);
  endproperty
  a_or_file: assert property (p_or_file)
    else $error("file OR result wrong");

  property p_or_file_dest_acc_kept;
    @(posedge SYS_CLK_I) disable iff (!RST_B_I)
      is_orf && dest_file |=> $stable(acc);
  endproperty
  a_or_file_dest_acc_kept: assert property (p_or_file_dest_acc_kept)
    else $error("file-destined OR touched accumulator");

  property p_zero_flag;
    @(posedge SYS_CLK_I) disable iff (!RST_B_I)
      (is_ori || is_orf) |=> zero == ($past(is_ori) ? ($past(ori_res) == '0)
        : ($past(orf_res) == '0));
  endproperty
  a_zero_flag: assert property (p_zero_flag)
    else $error("zero flag does not match result");
endmodule
`default_nettype wire

/* test/isx_core_tb.sv */
// Self-checking bench for the increment-skip and inclusive-OR execution unit
`timescale 1ns/1ps
`default_nettype none
module isx_core_tb;
  import isx_pkg::*;
  // =====================================================================
  // Stimulus and observed signals
  logic clk = 1'b0; // 10 MHz instruction clock
  logic rst_b = 1'b0; // Active low reset
  logic vld = 1'b0; // Instruction offered
  logic [INSTR_W-1:0] ins = '0; // Instruction word
  logic [ADDR_W-1:0] paddr = '0; // Observed file address
  logic [DATA_W-1:0] peek, acc; // Observed file value and accumulator
  logic zero, skp, exe, sq; // Flags and pulses
  // Reference state, mirrors the documented effects
  logic [DATA_W-1:0] m_file [0:FILE_DEPTH-1];
  logic [DATA_W-1:0] m_acc, e_peek;
  logic m_z, m_skip, m_ex, m_sq;
  logic [ADDR_W-1:0] last_f = '0; // Address of previous instruction
  logic [31:0] seed = 32'h7BDD; // Fixed seed keeps runs repeatable
  int failures = 0;
  int n_compared = 0;
  int cycles = 0;
  isx_core dut_u (.SYS_CLK_I(clk), .RST_B_I(rst_b), .INSTR_VALID_I(vld), .INSTR_I(ins),
    .PEEK_ADDR_I(paddr), .PEEK_DATA_O(peek), .ACC_O(acc), .ZERO_O(zero),
    .SKIP_PENDING_O(skp), .EXEC_O(exe), .SQUASH_O(sq));
  always #50 clk = ~clk;
  // Hang guard, far above the expected run length
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      stop_test();
    end
  end
  // =====================================================================
  // Helpers
  function automatic logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic stop_test();
    $display("compared %0d mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // One slot: check last results, offer a word, advance the reference
  task automatic step(input logic v, input logic [INSTR_W-1:0] w);
    logic [7:0] r;
    logic [6:0] f;
    @(negedge clk);
    check("acc", acc, m_acc);
    check("zero", {7'h00, zero}, {7'h00, m_z});
    check("skip", {7'h00, skp}, {7'h00, m_skip});
    check("exec", {7'h00, exe}, {7'h00, m_ex});
    check("squash", {7'h00, sq}, {7'h00, m_sq});
    check("file", peek, e_peek);
    vld = v;
    ins = w;
    paddr = last_f;
    e_peek = m_file[last_f];
    f = w[ADDR_MSB:0];
    last_f = f;
    m_ex = 1'b0;
    m_sq = 1'b0;
    // Reference: squash consumes the skip, otherwise execute the opcode
    if (v && m_skip) begin
      m_skip = 1'b0;
      m_sq = 1'b1;
    end else if (v) begin
      m_ex = 1'b1;
      r = (w[OPC_MSB:OPC_LSB] == 6'h03) ? (m_acc | m_file[f]) : m_file[f] + 8'h01;
      if (w[OPC_MSB:OPC_LSB] == 6'h02) begin
        m_acc = m_acc | w[LIT_MSB:0];
        m_z = (m_acc == 8'h00);
      end else if (w[OPC_MSB:OPC_LSB] == 6'h01 || w[OPC_MSB:OPC_LSB] == 6'h03) begin
        if (w[DEST_BIT]) m_file[f] = r;
        else m_acc = r;
        if (w[OPC_MSB:OPC_LSB] == 6'h01) m_skip = (r == 8'h00);
        else m_z = (r == 8'h00);
      end
    end
  endtask
  // =====================================================================
  // Main sequence
  logic [14:0] corner [0:12] = '{15'h4200, 15'h42FF, 15'h43FF, 15'h41FF, 15'h0000,
    15'h4255, 15'h4385, 15'h4105, 15'h41FF, 15'h4185, 15'h7F00, 15'h7F00, 15'h4300};
  initial begin
    for (int i = 0; i < FILE_DEPTH; i++) m_file[i] = FILE_RST;
    m_acc = ACC_RST;
    m_z = ZERO_RST;
    {m_skip, m_ex, m_sq, e_peek} = '0;
    repeat (10) @(negedge clk);
    rst_b = 1'b1;
    // Wrap to zero, idle slot keeps the skip, back-to-back squash, invalid opcode
    foreach (corner[i]) step(corner[i][14], corner[i][13:0]);
    $display("corner test done");
    for (int i = 0; i < 2000; i++) begin
      logic [5:0] op;
      seed = xs(seed);
      op = (seed[7:5] == 3'b000) ? 6'h3F : {4'h0, seed[4:3]};
      step(seed[2:0] != 3'b000, {op, (op == 6'h02) ? seed[19:12] :
        {seed[8], seed[9] ? 7'h7F : {5'h00, seed[11:10]}}});
    end
    step(1'b0, '0);
    $display("random test done");
    stop_test();
  end
endmodule
`default_nettype wire
